/* File: design/bfm_pkg.sv */
`default_nettype none
package bfm_pkg;
  // Wishbone register byte offsets
  localparam logic [7:0] ADDR_CFG_WORD  = 8'h00;
  localparam logic [7:0] ADDR_FAULT_OUT_PIN_WORD = 8'h04;
  localparam logic [7:0] ADDR_STATUS    = 8'h08;
  localparam logic [7:0] ADDR_POR       = 8'h0C;
  // Serial word layout
  localparam int WORD_BITS     = 16;
  localparam int ADDR_MSB      = 15;
  localparam int ADDR_LSB      = 13;
  localparam int WR_BIT        = 12;
  localparam logic [4:0] WORD_COUNT = 5'd16;
  // Register indices
  localparam logic [2:0] REG_TIMING = 3'd0;
  localparam logic [2:0] REG_THRESH = 3'd1;
  localparam logic [2:0] REG_MASK   = 3'd6;
  localparam logic [2:0] REG_RUN    = 3'd7;
  // Field positions
  localparam int BLANK_LSB   = 6;
  localparam int BLANK_MSB   = 9;
  localparam int THRESH_LSB  = 0;
  localparam int THRESH_MSB  = 5;
  localparam int RUN_BIT     = 0;
  localparam int HALT_BIT    = 6;
  // Diagnostic word bit positions
  localparam int DG_FF  = 15;
  localparam int DG_POR = 14;
  localparam int DG_VA  = 8;
  localparam int DG_AH  = 5;
  // Power-on values of the eight registers
  localparam logic [11:0] RST_VAL [8] = '{12'h214, 12'h3E0, 12'h010, 12'h054,
                                         12'h0F4, 12'h080, 12'h000, 12'h200};
  localparam logic [15:0] FAULT_OUT_PIN_POR_VAL = 16'hC000;
  // Timing
  localparam int CLK_HZ       = 20_000_000;
  localparam int BLANK_STEP_NS = 400;
  localparam int BLANK_STEP_CYC = (BLANK_STEP_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int THRESH_STEP_MV = 25;
  localparam int BOOT_TIMEOUT_US = 100;
  localparam int BOOT_TIMEOUT_CYC = BOOT_TIMEOUT_US * (CLK_HZ / 1_000_000);
  localparam int BLANK_W = 7;
  localparam int BOOT_W  = 12;
endpackage : bfm_pkg
`default_nettype wire

/* File: design/bfm_top.sv */
// What this block does
// - Brown-out repeats the full power-on reset
// - Recharge bootstrap via low side before high
// - Low bootstrap during high drive starts recharge
// - Recharge timeout: fault low, outputs off, bit
// - Bootstrap fault latched until reset or access
// - Threshold is 6-bit code times 25 mV
// - Blank delays comparison after each turn-on
// - Blank time is 4-bit code times 400 ns
// - Short after blank flags; halt latches it
// - Low-side excess shows short to supply
// - High-side excess shows short to ground
// - Any short drives fault output low
// - Fault pin untyped; diagnostic bits give type
// - Only serial run bit starts the motor
// - Shift serial input on rising clock
// - Ignore serial clock while strobe high
// - Sixteen bits then strobe rise commits word
// - Bad count discards, no reset, sets flag
// - Output MSB first, advance on falling edge
// - Top three bits address, bit 12 writes
// - Write returns diagnostic, read returns register
// - Diagnostic reset keeps still-active faults
//
// The implementer's own choices: the address map and the Wishbone register port.
`default_nettype none
module bfm_top
  import bfm_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        por_i,
  input  wire logic        reset_in_low_i,
  input  wire logic        strobe_n_i,
  input  wire logic        sck_i,
  input  wire logic        serial_in_i,
  output logic             serial_out_o,
  output logic             serial_out_oe_o,
  input  wire logic [2:0]  hs_req_i,
  input  wire logic [2:0]  ls_req_i,
  input  wire logic [2:0]  boot_ok_on_i,
  input  wire logic [2:0]  boot_ok_off_i,
  input  wire logic [2:0]  hs_vds_over_i,
  input  wire logic [2:0]  ls_vds_over_i,
  output logic [2:0]       hs_gate_o,
  output logic [2:0]       ls_gate_o,
  output logic [5:0]       short_threshold_code_o,
  output logic             fault_out_pin_o,
  output logic             motor_run_o,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o
);
  import bfm_pkg::*;

  typedef enum logic [2:0] {
    BS_IDLE   = 3'b001,
    BS_CHARGE = 3'b010,
    BS_DRIVE  = 3'b100
  } bfm_boot_t;

  typedef struct packed {
    logic [8*12-1:0]     regs;
    logic [15:0]         fault_out_pin;
    logic [15:0]         shift;
    logic [15:0]         out_word;
    logic [4:0]          edges;
    logic                sck_d;
    logic                stb_d;
    logic                serial_out;
    logic [2:0]          hs_d;
    logic [2:0]          ls_d;
    logic [6*BLANK_W-1:0] blank;
    logic [3*BOOT_W-1:0] boot_cnt;
    logic [8:0]          boot_st;
    logic [2:0]          boot_flt;
    logic [5:0]          short_lat;
    logic                ack;
    logic [31:0]         rdat;
  } bfm_state_t;

  bfm_state_t s_r, s_nxt;

  function automatic logic [11:0] reg_of(input logic [8*12-1:0] r, input logic [2:0] i);
    reg_of = r[i*12 +: 12];
  endfunction

  logic [11:0] timing_cfg_reg, threshold_cfg_reg, run_reg, mask_reg;
  logic        halt_on_fault;
  logic [3:0]  blank_count_code;
  logic [BLANK_W-1:0] blank_len;
  logic [5:0]  short_now, short_seen;
  logic [2:0]  boot_seen;
  logic [15:0] fault_out_pin_live;
  logic        outputs_off;
  logic        sck_rise, sck_fall, stb_fall, stb_rise;
  logic        fault_out_pin_clr;
  logic        wb_hit;

  always_comb begin
    timing_cfg_reg    = reg_of(s_r.regs, REG_TIMING);
    threshold_cfg_reg = reg_of(s_r.regs, REG_THRESH);
    run_reg           = reg_of(s_r.regs, REG_RUN);
    mask_reg          = reg_of(s_r.regs, REG_MASK);
    halt_on_fault     = run_reg[HALT_BIT];
    blank_count_code  = timing_cfg_reg[BLANK_MSB:BLANK_LSB];
    blank_len = BLANK_W'(blank_count_code * BLANK_STEP_CYC);
    sck_rise  = sck_i & ~s_r.sck_d & ~strobe_n_i;
    sck_fall  = ~sck_i & s_r.sck_d & ~strobe_n_i;
    stb_fall  = ~strobe_n_i & s_r.stb_d;
    stb_rise  = strobe_n_i & ~s_r.stb_d;
    for (int i = 0; i < 3; i++) begin
      // Blank-gated comparison; mask bits AH..CL sit at 5..0, high then low per phase
      short_now[2*i+1] = hs_vds_over_i[i] & s_r.hs_d[i] & ~mask_reg[DG_AH-2*i]
                         & (s_r.blank[(2*i+1)*BLANK_W +: BLANK_W] == '0);
      short_now[2*i]   = ls_vds_over_i[i] & s_r.ls_d[i] & ~mask_reg[DG_AH-1-2*i]
                         & (s_r.blank[(2*i)*BLANK_W +: BLANK_W] == '0);
      boot_seen[i] = s_r.boot_flt[i] & ~mask_reg[DG_VA-i];
    end
    short_seen = short_now | s_r.short_lat;
    outputs_off = (|s_r.boot_flt) | (halt_on_fault & (|s_r.short_lat));
    fault_out_pin_live = '0;
    for (int i = 0; i < 3; i++) begin
      fault_out_pin_live[DG_VA-i]     = boot_seen[i];
      fault_out_pin_live[DG_AH-2*i]   = short_now[2*i+1];
      fault_out_pin_live[DG_AH-1-2*i] = short_now[2*i];
    end
    wb_hit = wb_cyc_i & wb_stb_i & ~s_r.ack;
  end

  always_comb begin
    s_nxt = s_r;
    s_nxt.sck_d = sck_i;
    s_nxt.stb_d = strobe_n_i;
    s_nxt.hs_d  = hs_gate_o;
    s_nxt.ls_d  = ls_gate_o;
    fault_out_pin_clr = 1'b0;
    // Serial port
    if (stb_fall) begin
      s_nxt.edges = '0;
      s_nxt.out_word = s_r.fault_out_pin;
      s_nxt.serial_out = s_r.fault_out_pin[DG_FF];
    end else if (sck_rise) begin
      s_nxt.shift = {s_r.shift[14:0], serial_in_i};
      if (s_r.edges != 5'h1F)
        s_nxt.edges = s_r.edges + 5'd1;
      if (s_r.edges == 5'd0)
        s_nxt.out_word = s_r.fault_out_pin;
      if (s_r.edges == 5'd3) begin
        // Once address and write flag are in, choose the return word
        // Four bits (15..12) already left; load the rest pre-shifted so bit 11 goes out next
        if (!serial_in_i)
          s_nxt.out_word = {1'b0, reg_of(s_r.regs, s_r.shift[2:0]), 3'b000};
        else
          s_nxt.out_word = {s_r.fault_out_pin[12:0], 3'b000};
      end
    end else if (sck_fall) begin
      s_nxt.out_word = {s_r.out_word[14:0], 1'b0};
      s_nxt.serial_out = s_r.out_word[14];
    end
    if (stb_rise) begin
      if (s_r.edges == WORD_COUNT) begin
        if (s_r.shift[WR_BIT])
          s_nxt.regs[s_r.shift[ADDR_MSB:ADDR_LSB]*12 +: 12] = s_r.shift[11:0];
        fault_out_pin_clr = 1'b1;
      end else begin
        s_nxt.fault_out_pin[DG_FF] = 1'b1;
      end
    end
    if (!reset_in_low_i)
      fault_out_pin_clr = 1'b1;
    // Per-MOSFET blank timers
    for (int i = 0; i < 3; i++) begin
      if (hs_gate_o[i] & ~s_r.hs_d[i])
        s_nxt.blank[(2*i+1)*BLANK_W +: BLANK_W] = blank_len;
      else if (s_r.blank[(2*i+1)*BLANK_W +: BLANK_W] != '0)
        s_nxt.blank[(2*i+1)*BLANK_W +: BLANK_W] = s_r.blank[(2*i+1)*BLANK_W +: BLANK_W] - 1'b1;
      if (ls_gate_o[i] & ~s_r.ls_d[i])
        s_nxt.blank[(2*i)*BLANK_W +: BLANK_W] = blank_len;
      else if (s_r.blank[(2*i)*BLANK_W +: BLANK_W] != '0)
        s_nxt.blank[(2*i)*BLANK_W +: BLANK_W] = s_r.blank[(2*i)*BLANK_W +: BLANK_W] - 1'b1;
    end
    // Bootstrap management per phase
    for (int i = 0; i < 3; i++) begin
      case (s_r.boot_st[3*i +: 3])
        BS_IDLE: begin
          if (hs_req_i[i] & run_reg[RUN_BIT] & ~outputs_off) begin
            s_nxt.boot_st[3*i +: 3] = boot_ok_on_i[i] ? BS_DRIVE : BS_CHARGE;
            s_nxt.boot_cnt[BOOT_W*i +: BOOT_W] = '0;
          end
        end
        BS_CHARGE: begin
          if (boot_ok_on_i[i])
            s_nxt.boot_st[3*i +: 3] = BS_DRIVE;
          else if (s_r.boot_cnt[BOOT_W*i +: BOOT_W] == BOOT_W'(BOOT_TIMEOUT_CYC - 1)) begin
            s_nxt.boot_flt[i] = ~mask_reg[DG_VA-i];
            s_nxt.boot_st[3*i +: 3] = BS_IDLE;
          end else
            s_nxt.boot_cnt[BOOT_W*i +: BOOT_W] = s_r.boot_cnt[BOOT_W*i +: BOOT_W] + 1'b1;
        end
        BS_DRIVE: begin
          if (~hs_req_i[i] | outputs_off | ~run_reg[RUN_BIT])
            s_nxt.boot_st[3*i +: 3] = BS_IDLE;
          else if (~boot_ok_off_i[i]) begin
            s_nxt.boot_st[3*i +: 3] = BS_CHARGE;
            s_nxt.boot_cnt[BOOT_W*i +: BOOT_W] = '0;
          end
        end
        default: s_nxt.boot_st[3*i +: 3] = BS_IDLE;
      endcase
    end
    // Fault latching; set wins over clear
    if (fault_out_pin_clr) begin
      s_nxt.fault_out_pin = fault_out_pin_live;
      s_nxt.boot_flt = s_nxt.boot_flt & ~s_r.boot_flt;
      s_nxt.short_lat = short_now;
      if (stb_rise && s_r.edges != WORD_COUNT)
        s_nxt.fault_out_pin[DG_FF] = 1'b1;
    end else begin
      s_nxt.fault_out_pin = s_nxt.fault_out_pin | fault_out_pin_live;
      if (halt_on_fault)
        s_nxt.short_lat = s_r.short_lat | short_now;
    end
    if (|s_nxt.fault_out_pin[13:0])
      s_nxt.fault_out_pin[DG_FF] = 1'b1;
    // Wishbone slave
    s_nxt.ack = wb_hit;
    s_nxt.rdat = '0;
    if (wb_hit) begin
      case (wb_adr_i)
        ADDR_CFG_WORD: s_nxt.rdat = {20'h0_0000, threshold_cfg_reg};
        ADDR_FAULT_OUT_PIN_WORD: s_nxt.rdat = {16'h0000, s_r.fault_out_pin};
        ADDR_STATUS: s_nxt.rdat = {26'h000_0000, short_seen};
        default: s_nxt.rdat = '0;
      endcase
      if (wb_we_i && wb_adr_i == ADDR_STATUS && wb_sel_i[0])
        s_nxt.short_lat = s_nxt.short_lat & ~wb_dat_i[5:0] | short_now;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || por_i) begin
      s_r <= '0;
      s_r.regs <= {RST_VAL[7], RST_VAL[6], RST_VAL[5], RST_VAL[4],
                   RST_VAL[3], RST_VAL[2], RST_VAL[1], RST_VAL[0]};
      s_r.fault_out_pin <= FAULT_OUT_PIN_POR_VAL;
      s_r.boot_st <= {BS_IDLE, BS_IDLE, BS_IDLE};
      s_r.sck_d <= 1'b0;
      s_r.stb_d <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  always_comb begin
    for (int i = 0; i < 3; i++) begin
      hs_gate_o[i] = (s_r.boot_st[3*i +: 3] == BS_DRIVE) & ~outputs_off;
      ls_gate_o[i] = ((s_r.boot_st[3*i +: 3] == BS_CHARGE) | (ls_req_i[i] & ~hs_req_i[i]))
                     & run_reg[RUN_BIT] & ~outputs_off;
    end
  end

  assign motor_run_o            = run_reg[RUN_BIT] & ~outputs_off;
  assign short_threshold_code_o = threshold_cfg_reg[THRESH_MSB:THRESH_LSB];
  assign fault_out_pin_o        = ~(|short_seen | outputs_off);
  assign serial_out_o           = s_r.serial_out;
  assign serial_out_oe_o        = ~strobe_n_i;
  assign wb_dat_o               = s_r.rdat;
  assign wb_ack_o               = s_r.ack;
endmodule : bfm_top
`default_nettype wire

/* File: verification/bfm_host.sv */
`default_nettype none
module bfm_host (
  input  wire logic clk_i,
  input  wire logic sdo_i,
  output logic      strobe_n_o,
  output logic      sck_o,
  output logic      sdi_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    strobe_n_o = 1'b1;
    sck_o = 1'b0;
    sdi_o = 1'b0;
  end
  // One frame of n clock pulses, each high for three system clocks and low for six
  task automatic xfer(input logic [15:0] w, input int n, output logic [15:0] rd);
    rd = 16'h0000;
    @(posedge clk_i);
    strobe_n_o <= 1'b0;
    for (int i = 0; i < n; i++) begin
      repeat (3) @(posedge clk_i);
      sdi_o <= (i < 16) ? w[15 - i] : ~sdi_o;
      repeat (3) @(posedge clk_i);
      rd = {rd[14:0], sdo_i};
      sck_o <= 1'b1;
      repeat (3) @(posedge clk_i);
      sck_o <= 1'b0;
    end
    repeat (3) @(posedge clk_i);
    strobe_n_o <= 1'b1;
    sdi_o <= ~sdi_o;
    repeat (3) @(posedge clk_i);
  endtask
endmodule // bfm_host
`default_nettype wire

/* File: verification/bfm_sva.sv */
`default_nettype none
module bfm_sva (
  input wire logic       clk_i,
  input wire logic       rst_i,
  input wire logic       por_i,
  input wire logic       strobe_n_i,
  input wire logic       serial_out_oe_o,
  input wire logic [2:0] hs_gate_o,
  input wire logic [2:0] ls_gate_o,
  input wire logic [2:0] boot_ok_on_i,
  input wire logic [2:0] hs_vds_over_i,
  input wire logic [5:0] short_threshold_code_o,
  input wire logic       fault_out_pin_o,
  input wire logic       motor_run_o,
  input wire logic       wb_cyc_i,
  input wire logic       wb_stb_i,
  input wire logic       wb_ack_o
);
  logic [7:0] over_cnt;
  // Cycles of phase A high side on with its drain-source over threshold
  always_ff @(posedge clk_i) begin
    if (rst_i || por_i || !(hs_gate_o[0] && hs_vds_over_i[0])) begin
      over_cnt <= 8'h00;
    end else if (over_cnt != 8'hFF) begin
      over_cnt <= over_cnt + 8'h01;
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i || por_i);
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  a_oe_strobe: assert property (serial_out_oe_o == !strobe_n_i)
    else $error("serial output enable does not follow strobe");
  a_ack_pulse: assert property (s_req |=> wb_ack_o)
    else $error("bus request not answered in one cycle");
  a_ack_drop: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("bus acknowledge held too long");
  a_run_commit: assert property ($rose(motor_run_o) |-> strobe_n_i)
    else $error("motor started inside a serial frame");
  a_high_boot: assert property ($rose(hs_gate_o[0]) |-> $past(boot_ok_on_i[0]))
    else $error("high side on without bootstrap charge");
  a_rst_clean: assert property (disable iff (por_i) $fell(rst_i) |->
    hs_gate_o == 3'h0 && ls_gate_o == 3'h0 && fault_out_pin_o)
    else $error("outputs not clean after reset");
  a_por_clean: assert property (disable iff (rst_i) $fell(por_i) |->
    hs_gate_o == 3'h0 && ls_gate_o == 3'h0 && fault_out_pin_o)
    else $error("outputs not clean after power-on reset");
  a_thr_commit: assert property ($changed(short_threshold_code_o) |-> strobe_n_i)
    else $error("threshold changed inside a frame");
  a_blank_wait: assert property ($fell(hs_gate_o[0]) && over_cnt != 8'h00 |->
    over_cnt >= 8'd60)
    else $error("short acted on before blank time");
endmodule // bfm_sva
bind bfm_top bfm_sva u_sva (.clk_i(clk_i), .rst_i(rst_i), .por_i(por_i),
  .strobe_n_i(strobe_n_i), .serial_out_oe_o(serial_out_oe_o), .hs_gate_o(hs_gate_o),
  .ls_gate_o(ls_gate_o), .boot_ok_on_i(boot_ok_on_i), .hs_vds_over_i(hs_vds_over_i),
  .short_threshold_code_o(short_threshold_code_o), .fault_out_pin_o(fault_out_pin_o),
  .motor_run_o(motor_run_o), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o));
`default_nettype wire

/* File: verification/tb_top.sv */
`default_nettype none
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin error_cnt++; \
  $display("ERROR t=%0t got %h exp %h", $time, (a), (e)); end end
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import bfm_pkg::*;
  logic        clk_i = 1'b0, rst_i = 1'b1, por_i = 1'b0, rst_low_n = 1'b1;
  logic        wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0, wb_ack, fault_pin, run;
  logic [2:0]  hs_req = 3'h0, ok_on = 3'h7, ok_off = 3'h7, hs_over = 3'h0, hs_gate, ls_gate;
  logic [7:0]  wb_adr = 8'h00;
  logic [31:0] wb_wdat = 32'h0000_0000, wb_rdat, rdat;
  logic [5:0]  thr;
  logic [15:0] rd;
  logic        strobe_n, sck, serial_in, serial_out;
  int          error_cnt = 0, samples_checked = 0, k;
  always #25 clk_i = ~clk_i;
  bfm_host u_host (.clk_i(clk_i), .sdo_i(serial_out), .strobe_n_o(strobe_n), .sck_o(sck), .sdi_o(serial_in));
  bfm_top u_dut (.clk_i(clk_i), .rst_i(rst_i), .por_i(por_i), .reset_in_low_i(rst_low_n),
    .strobe_n_i(strobe_n), .sck_i(sck), .serial_in_i(serial_in), .serial_out_o(serial_out),
    .serial_out_oe_o(), .hs_req_i(hs_req), .ls_req_i(3'h0), .boot_ok_on_i(ok_on),
    .boot_ok_off_i(ok_off), .hs_vds_over_i(hs_over), .ls_vds_over_i(3'h0),
    .hs_gate_o(hs_gate), .ls_gate_o(ls_gate), .short_threshold_code_o(thr),
    .fault_out_pin_o(fault_pin), .motor_run_o(run), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
    .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(4'hF), .wb_dat_i(wb_wdat),
    .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack));
  task automatic end_sim;
    $display("mismatches %0d comparisons %0d", error_cnt, samples_checked);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc <= 1'b1; wb_stb <= 1'b1; wb_we <= we; wb_adr <= a; wb_wdat <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack !== 1'b1 && n < 20);
    rdat = wb_rdat;
    if (wb_ack !== 1'b1) begin
      error_cnt++;
      end_sim();
    end
    wb_cyc <= 1'b0; wb_stb <= 1'b0;
  endtask
  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      u_host.xfer({i[2:0], 1'b0, 12'h000}, 16, rd);
      `CHK(rd, {(i == 0) ? 3'b110 : 3'b000, 1'b0, RST_VAL[i]})
    end
    u_host.xfer({REG_THRESH, 1'b1, 12'h02A}, 16, rd);
    `CHK(rd, 16'h0000)
    repeat (4) @(posedge clk_i);
    `CHK(thr, 6'h2A)
    wb(1'b0, ADDR_CFG_WORD, 32'h0000_0000);
    `CHK(rdat, 32'h0000_002A)
    u_host.xfer({REG_THRESH, 1'b1, 12'h015}, 15, rd);
    u_host.xfer({REG_THRESH, 1'b1, 12'h015}, 17, rd);
    `CHK(thr, 6'h2A)
    wb(1'b0, ADDR_FAULT_OUT_PIN_WORD, 32'h0000_0000);
    `CHK(rdat, 32'h0000_8000)
    u_host.xfer({REG_THRESH, 1'b0, 12'h000}, 16, rd);
    `CHK(rd, 16'h802A)
    wb(1'b0, 8'h10, 32'h0000_0000);
    `CHK(rdat, 32'h0000_0000)
    hs_req <= 3'h1;
    repeat (10) @(posedge clk_i);
    `CHK(run, 1'b0)
    u_host.xfer({REG_RUN, 1'b1, 12'h241}, 16, rd);
    `CHK(run, 1'b1)
    ok_on <= 3'h0; ok_off <= 3'h0;
    repeat (5) @(posedge clk_i);
    `CHK(ls_gate, 3'h1)
    k = 0;
    while (fault_pin === 1'b1 && k < 3000) begin
      @(posedge clk_i);
      k++;
    end
    `CHK(k inside {[1900:2100]}, 1'b1)
    `CHK({hs_gate, ls_gate}, 6'h00)
    wb(1'b0, ADDR_FAULT_OUT_PIN_WORD, 32'h0000_0000);
    `CHK(rdat, 32'h0000_8100)
    hs_req <= 3'h0; ok_on <= 3'h7; ok_off <= 3'h7; rst_low_n <= 1'b0;
    repeat (2) @(posedge clk_i);
    rst_low_n <= 1'b1;
    repeat (4) @(posedge clk_i);
    `CHK(fault_pin, 1'b1)
    hs_over <= 3'h1; hs_req <= 3'h1;
    repeat (30) @(posedge clk_i);
    `CHK(fault_pin, 1'b1)
    repeat (70) @(posedge clk_i);
    `CHK({fault_pin, hs_gate}, 4'h0)
    wb(1'b0, ADDR_FAULT_OUT_PIN_WORD, 32'h0000_0000);
    `CHK(rdat, 32'h0000_8020)
    hs_over <= 3'h0; hs_req <= 3'h0;
    wb(1'b1, ADDR_STATUS, 32'h0000_003F);
    wb(1'b0, ADDR_STATUS, 32'h0000_0000);
    `CHK(rdat, 32'h0000_0000)
    u_host.xfer({REG_RUN, 1'b1, 12'h240}, 16, rd);
    `CHK(run, 1'b0)
    por_i <= 1'b1;
    @(posedge clk_i);
    por_i <= 1'b0;
    wb(1'b0, ADDR_FAULT_OUT_PIN_WORD, 32'h0000_0000);
    `CHK({rdat, thr}, {32'h0000_C000, 6'h20})
    end_sim();
  end
endmodule // tb_top
`default_nettype wire
